// [rxohs_pkg.sv]
// Operation
// - Timeslot monitor shows selected receive slot, first bit in bit 7, last in bit 0.
// - Firmware revision at 061h is read-only; writes do nothing.
// - T1 offset 062h captures data link or Fs bits, bit 7 most significant.
// - T1 data link byte assembled with first received bit in bit 0.
// - D4 mode: link register updates at multiframe boundary, six Fs bits in 5:0.
// - Offset 062h reads link register in T1, real-time sync status in E1.
// - Real-time status bits show current state, never latched.
// - Search counter adds one per expired 8 ms multiframe search.
// - Search counter clears when multiframe sync is reached.
// - Search counter clears while multiframe mode enable is zero.
// - Search counter saturates at maximum, never wraps.
// - Six-bit counter; status bits 7..3 show counter bits 5,4,3,2,0.
// - Status bit 2 high while hunting multiframe alignment word.
// - Status bit 1 high while hunting signaling multiframe word.
// - Status bit 0 high while hunting basic frame alignment.
// - Code register at 063h holds last valid 6-bit code taken in T1 mode; bits 7,6 zero; reads zero in E1.
// - T1 mode: three SLC-96 link registers show C, M, A and S bits.
// - E1 offset 064h shows alignment-frame byte, international bit in bit 7.
// - E1 offset 065h shows non-alignment byte: Si, one, alarm, five spare bits.
// - Each of eight ports decodes its copy at offset plus 200h times index.
package rxohs_pkg;
	localparam int          ADDR_W           = 12;
	localparam int          DATA_W           = 8;
	localparam int          PORT_CNT         = 8;
	localparam int          PORT_LSB         = 9;
	localparam logic [11:0] PORT_STRIDE      = 12'h0200;

	localparam logic [8:0]  OFF_TS_MONITOR   = 9'h060;
	localparam logic [8:0]  OFF_FW_REVISION  = 9'h061;
	localparam logic [8:0]  OFF_LINK_STATUS  = 9'h062;
	localparam logic [8:0]  OFF_CODE         = 9'h063;
	localparam logic [8:0]  OFF_SLC1_ALIGN   = 9'h064;
	localparam logic [8:0]  OFF_SLC2_NALIGN  = 9'h065;
	localparam logic [8:0]  OFF_SLC3         = 9'h066;
	localparam logic [8:0]  OFF_MON_SELECT   = 9'h07E;
	localparam logic [8:0]  OFF_CONTROL      = 9'h07F;

	localparam int          CTRL_T1_MODE     = 0;
	localparam int          CTRL_CRC4_ENABLE = 1;
	localparam int          CTRL_D4_MODE     = 2;
	localparam int          CTRL_W           = 3;

	localparam logic [7:0]  RST_BYTE         = 8'h00;
	localparam logic [5:0]  RST_CODE         = 6'h00;
	localparam logic [4:0]  RST_SELECT       = 5'h00;
	localparam logic [2:0]  RST_CONTROL      = 3'h0;

	localparam int          SEARCH_CNT_W     = 6;
	localparam int          SEARCH_TIME_MS   = 8;
	localparam int          ABANDON_TIME_MS  = 400;
	localparam int          FS_BITS          = 6;
	localparam int          CODE_W           = 6;
	localparam int          SLOT_W           = 5;
	localparam int          SLOT_CNT         = 32;
endpackage : rxohs_pkg

// [rxohs_shifter.sv]
`timescale 1ns/1ps
module rxohs_shifter #(
	parameter int WIDTH     = 8,
	parameter bit LSB_FIRST = 1'b1
) (
	input  wire logic             ref_clk_i,
	input  wire logic             srst_i,
	input  wire logic             bit_en_i,
	input  wire logic             bit_i,
	input  wire logic             start_i,
	output logic [WIDTH-1:0]      word_o,
	output logic                  done_o
);
	localparam int CNT_W = $clog2(WIDTH + 1);

	// Refused at elaboration, so a bad width never reaches a netlist
	if (WIDTH < 2 || WIDTH > 16) begin : g_bad_width
		$error("rxohs_shifter: WIDTH out of range");
	end

	logic [WIDTH-1:0] word_ff;
	logic [CNT_W-1:0] cnt_ff;
	logic             done_ff;
	logic [WIDTH-1:0] nxt_word;
	logic [CNT_W-1:0] base_cnt;
	logic             last_bit;

	assign nxt_word = LSB_FIRST ? {bit_i, word_ff[WIDTH-1:1]} : {word_ff[WIDTH-2:0], bit_i};
	// A start bit realigns the unit, so a lost bit heals at the next unit
	assign base_cnt = start_i ? '0 : cnt_ff;
	assign last_bit = bit_en_i && (base_cnt == CNT_W'(WIDTH - 1));

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			word_ff <= '0;
			cnt_ff  <= '0;
			done_ff <= 1'b0;
		end else begin
			done_ff <= last_bit;
			if (bit_en_i) begin
				word_ff <= nxt_word;
				cnt_ff  <= last_bit ? '0 : base_cnt + CNT_W'(1);
			end
		end
	end

	assign word_o = word_ff;
	assign done_o = done_ff;
endmodule : rxohs_shifter

// [rxohs_search_counter.sv]
`timescale 1ns/1ps
module rxohs_search_counter
	import rxohs_pkg::*;
#(
	parameter int WIDTH = rxohs_pkg::SEARCH_CNT_W
) (
	input  wire logic             ref_clk_i,
	input  wire logic             srst_i,
	input  wire logic             crc4_mode_enable_i,
	input  wire logic             search_expired_i,
	input  wire logic             mf_sync_found_i,
	output logic [WIDTH-1:0]      count_o
);
	if (WIDTH != SEARCH_CNT_W) begin : g_bad_width
		$error("rxohs_search_counter: status layout needs a six-bit counter");
	end

	logic [WIDTH-1:0] count_ff;
	logic             at_max;
	logic             clear;

	assign at_max = &count_ff;
	assign clear  = mf_sync_found_i || !crc4_mode_enable_i;

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			count_ff <= '0;
		end else if (clear) begin
			count_ff <= '0;
		end else if (search_expired_i && !at_max) begin
			count_ff <= count_ff + WIDTH'(1);
		end
	end

	assign count_o = count_ff;
endmodule : rxohs_search_counter

// [rxohs_regs.sv]
`timescale 1ns/1ps
module rxohs_regs
	import rxohs_pkg::*;
#(
	parameter logic [2:0] PORT_INDEX  = 3'h0,
	// Arbitrary value, stands in for the receive firmware build
	parameter logic [7:0] FW_REVISION = 8'h00
) (
	input  wire logic                           ref_clk_i,
	input  wire logic                           srst_i,
	input  wire logic [rxohs_pkg::ADDR_W-1:0]   reg_addr_i,
	input  wire logic [rxohs_pkg::DATA_W-1:0]   reg_wdata_i,
	input  wire logic                           reg_wr_i,
	input  wire logic                           reg_rd_i,
	output logic      [rxohs_pkg::DATA_W-1:0]   reg_rdata_o,
	input  wire logic                           rx_bit_en_i,
	input  wire logic                           rx_bit_i,
	input  wire logic [rxohs_pkg::SLOT_W-1:0]   rx_slot_i,
	input  wire logic [2:0]                     rx_bit_pos_i,
	input  wire logic                           rx_link_bit_en_i,
	input  wire logic                           rx_link_bit_i,
	input  wire logic                           rx_link_start_i,
	input  wire logic                           rx_fs_bit_en_i,
	input  wire logic                           rx_fs_bit_i,
	input  wire logic                           rx_fs_start_i,
	input  wire logic                           rx_mf_boundary_i,
	input  wire logic                           rx_code_valid_i,
	input  wire logic [rxohs_pkg::CODE_W-1:0]   rx_code_i,
	input  wire logic                           rx_slc_valid_i,
	input  wire logic [10:0]                    rx_slc_c_i,
	input  wire logic [2:0]                     rx_slc_m_i,
	input  wire logic [1:0]                     rx_slc_a_i,
	input  wire logic [3:0]                     rx_slc_s_i,
	input  wire logic [3:0]                     rx_slc_sfix_i,
	input  wire logic                           rx_ts0_valid_i,
	input  wire logic                           rx_ts0_is_align_i,
	input  wire logic [7:0]                     rx_ts0_i,
	input  wire logic                           rx_frame_sync_i,
	input  wire logic                           crc4_mf_hunt_active_i,
	input  wire logic                           signaling_mf_hunt_active_i,
	input  wire logic                           frame_align_hunt_active_i,
	input  wire logic                           crc4_search_expired_i,
	input  wire logic                           crc4_mf_sync_found_i,
	output logic                                t1_mode_o,
	output logic                                crc4_mode_enable_o,
	output logic                                d4_mode_o,
	output logic      [rxohs_pkg::SLOT_W-1:0]   rx_channel_monitor_select_o
);
	if (PORT_INDEX > 3'(PORT_CNT - 1)) begin : g_bad_port
		$error("rxohs_regs: PORT_INDEX beyond port count");
	end
	if (PORT_STRIDE != (12'h001 << PORT_LSB)) begin : g_bad_stride
		$error("rxohs_regs: port stride must match port field");
	end

	// Address decode

	logic       port_hit;
	logic [8:0] local_off;
	logic       wr_hit;

	assign port_hit  = reg_addr_i[ADDR_W-1:PORT_LSB] == PORT_INDEX;
	assign local_off = reg_addr_i[PORT_LSB-1:0];
	assign wr_hit    = reg_wr_i && port_hit;

	// Software controls

	logic [CTRL_W-1:0] control_ff;
	logic [SLOT_W-1:0] mon_select_ff;
	logic              t1_mode;
	logic              crc4_enable;
	logic              d4_mode;

	assign t1_mode     = control_ff[CTRL_T1_MODE];
	assign crc4_enable = control_ff[CTRL_CRC4_ENABLE];
	assign d4_mode     = control_ff[CTRL_D4_MODE];

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			control_ff    <= RST_CONTROL;
			mon_select_ff <= RST_SELECT;
		end else begin
			if (wr_hit && local_off == OFF_CONTROL)
				control_ff <= reg_wdata_i[CTRL_W-1:0];
			if (wr_hit && local_off == OFF_MON_SELECT)
				mon_select_ff <= reg_wdata_i[SLOT_W-1:0];
		end
	end

	// Timeslot monitor

	logic       mon_bit_en;
	logic       mon_start;
	logic [7:0] mon_word;
	logic       mon_done;
	logic [7:0] ts_monitor_ff;

	assign mon_bit_en = rx_bit_en_i && (rx_slot_i == mon_select_ff);
	assign mon_start  = rx_bit_pos_i == 3'h0;

	rxohs_shifter #(
		.WIDTH     (8),
		.LSB_FIRST (1'b0)
	) u_mon_shift (
		.ref_clk_i (ref_clk_i),
		.srst_i    (srst_i),
		.bit_en_i  (mon_bit_en),
		.bit_i     (rx_bit_i),
		.start_i   (mon_start),
		.word_o    (mon_word),
		.done_o    (mon_done)
	);

	always_ff @(posedge ref_clk_i) begin
		if (srst_i)
			ts_monitor_ff <= RST_BYTE;
		else if (mon_done)
			ts_monitor_ff <= mon_word;
	end

	// T1 facility link and Fs bits

	logic [7:0]         link_word;
	logic               link_done;
	logic [FS_BITS-1:0] fs_word;
	logic [7:0]         link_ff;

	rxohs_shifter #(
		.WIDTH     (8),
		.LSB_FIRST (1'b1)
	) u_link_shift (
		.ref_clk_i (ref_clk_i),
		.srst_i    (srst_i),
		.bit_en_i  (rx_link_bit_en_i),
		.bit_i     (rx_link_bit_i),
		.start_i   (rx_link_start_i),
		.word_o    (link_word),
		.done_o    (link_done)
	);

	// Fs bits arrive first-received first, so it lands in bit 0 as well
	rxohs_shifter #(
		.WIDTH     (FS_BITS),
		.LSB_FIRST (1'b1)
	) u_fs_shift (
		.ref_clk_i (ref_clk_i),
		.srst_i    (srst_i),
		.bit_en_i  (rx_fs_bit_en_i),
		.bit_i     (rx_fs_bit_i),
		.start_i   (rx_fs_start_i),
		.word_o    (fs_word),
		.done_o    ()
	);

	logic link_load;
	logic fs_load;

	assign link_load = t1_mode && !d4_mode && link_done;
	assign fs_load   = t1_mode && d4_mode && rx_mf_boundary_i;

	always_ff @(posedge ref_clk_i) begin
		if (srst_i)
			link_ff <= RST_BYTE;
		else if (fs_load)
			link_ff <= {2'b00, fs_word};
		else if (link_load)
			link_ff <= link_word;
	end

	// Bit-oriented code

	logic [CODE_W-1:0] code_ff;

	always_ff @(posedge ref_clk_i) begin
		if (srst_i)
			code_ff <= RST_CODE;
		else if (t1_mode && rx_code_valid_i)
			code_ff <= rx_code_i;
	end

	// SLC-96 link, three bytes captured together per superframe

	logic [7:0] slc1_ff;
	logic [7:0] slc2_ff;
	logic [7:0] slc3_ff;
	logic [7:0] nxt_slc1;
	logic [7:0] nxt_slc2;
	logic [7:0] nxt_slc3;

	assign nxt_slc1 = rx_slc_c_i[7:0];
	assign nxt_slc2 = {rx_slc_m_i[1:0], rx_slc_sfix_i[2:0], rx_slc_c_i[10:8]};
	assign nxt_slc3 = {rx_slc_sfix_i[3], rx_slc_s_i, rx_slc_a_i, rx_slc_m_i[2]};

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			slc1_ff <= RST_BYTE;
			slc2_ff <= RST_BYTE;
			slc3_ff <= RST_BYTE;
		end else if (t1_mode && rx_slc_valid_i) begin
			slc1_ff <= nxt_slc1;
			slc2_ff <= nxt_slc2;
			slc3_ff <= nxt_slc3;
		end
	end

	// E1 timeslot-0 words

	logic [7:0] align_ff;
	logic [7:0] nalign_ff;
	logic       ts0_take;

	// Out of sync the slot-0 byte is garbage, so the last good word stays
	assign ts0_take = !t1_mode && rx_ts0_valid_i && rx_frame_sync_i;

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			align_ff  <= RST_BYTE;
			nalign_ff <= RST_BYTE;
		end else if (ts0_take) begin
			if (rx_ts0_is_align_i)
				align_ff <= rx_ts0_i;
			else
				nalign_ff <= rx_ts0_i;
		end
	end

	// E1 real-time synchronizer status

	logic [SEARCH_CNT_W-1:0] search_count;
	logic [7:0]              rt_status;

	rxohs_search_counter #(
		.WIDTH (SEARCH_CNT_W)
	) u_search (
		.ref_clk_i          (ref_clk_i),
		.srst_i             (srst_i),
		.crc4_mode_enable_i (crc4_enable),
		.search_expired_i   (crc4_search_expired_i),
		.mf_sync_found_i    (crc4_mf_sync_found_i),
		.count_o            (search_count)
	);

	// Bit 1 of the count is dropped so five bits still span beyond 400 ms
	assign rt_status = {
		search_count[5:2],
		search_count[0],
		crc4_mf_hunt_active_i,
		signaling_mf_hunt_active_i,
		frame_align_hunt_active_i
	};

	// Read mux

	function automatic logic [7:0] read_mux(
		input logic [8:0] off,
		input logic       t1
	);
		logic [7:0] val;
		val = RST_BYTE;
		unique case (off)
			OFF_TS_MONITOR:  val = ts_monitor_ff;
			OFF_FW_REVISION: val = FW_REVISION;
			OFF_LINK_STATUS: val = t1 ? link_ff : rt_status;
			OFF_CODE:        val = t1 ? {2'b00, code_ff} : RST_BYTE;
			OFF_SLC1_ALIGN:  val = t1 ? slc1_ff : align_ff;
			OFF_SLC2_NALIGN: val = t1 ? slc2_ff : nalign_ff;
			OFF_SLC3:        val = t1 ? slc3_ff : RST_BYTE;
			OFF_MON_SELECT:  val = {3'b000, mon_select_ff};
			OFF_CONTROL:     val = {5'b00000, control_ff};
			default:         val = RST_BYTE;
		endcase
		return val;
	endfunction : read_mux

	logic [7:0] rd_value;
	logic [7:0] rdata_ff;

	assign rd_value = (reg_rd_i && port_hit) ? read_mux(local_off, t1_mode) : RST_BYTE;

	// Reads only sample; no captured value or counter moves on a read
	always_ff @(posedge ref_clk_i) begin
		if (srst_i)
			rdata_ff <= RST_BYTE;
		else
			rdata_ff <= rd_value;
	end

	assign reg_rdata_o                 = rdata_ff;
	assign t1_mode_o                   = t1_mode;
	assign crc4_mode_enable_o          = crc4_enable;
	assign d4_mode_o                   = d4_mode;
	assign rx_channel_monitor_select_o = mon_select_ff;
endmodule : rxohs_regs

// [rxohs_regs_monitor.sv]
`timescale 1ns/1ps
module rxohs_regs_chk #(
	parameter logic [2:0] PORT_INDEX  = 3'h0,
	parameter logic [7:0] FW_REVISION = 8'h00
) (
	input logic        ref_clk_i,
	input logic        srst_i,
	input logic [11:0] reg_addr_i,
	input logic        reg_wr_i,
	input logic        reg_rd_i,
	input logic [7:0]  reg_rdata_o,
	input logic        rx_code_valid_i,
	input logic [5:0]  rx_code_i,
	input logic        rx_ts0_valid_i,
	input logic        rx_ts0_is_align_i,
	input logic [7:0]  rx_ts0_i,
	input logic        rx_frame_sync_i,
	input logic        crc4_mf_hunt_active_i,
	input logic        signaling_mf_hunt_active_i,
	input logic        frame_align_hunt_active_i,
	input logic        t1_mode_o,
	input logic        crc4_mode_enable_o,
	input logic        d4_mode_o,
	input logic [4:0]  rx_channel_monitor_select_o
);
	import rxohs_pkg::*;
	wire       mine    = reg_addr_i[11:9] == PORT_INDEX;
	wire       rd_fw   = reg_rd_i && mine && reg_addr_i[8:0] == OFF_FW_REVISION;
	wire       rd_link = reg_rd_i && mine && reg_addr_i[8:0] == OFF_LINK_STATUS;
	wire       rd_code = reg_rd_i && mine && reg_addr_i[8:0] == OFF_CODE;
	wire       rd_af   = reg_rd_i && mine && reg_addr_i[8:0] == OFF_SLC1_ALIGN;
	wire       wr_fw   = reg_wr_i && mine && reg_addr_i[8:0] == OFF_FW_REVISION;
	wire [2:0] hunt    = {crc4_mf_hunt_active_i, signaling_mf_hunt_active_i, frame_align_hunt_active_i};
	wire [7:0] ctrl    = {t1_mode_o, crc4_mode_enable_o, d4_mode_o, rx_channel_monitor_select_o};
	logic [5:0] last_code_ff;
	logic [7:0] last_af_ff;
	// Reference copies of the last accepted captures
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			last_code_ff <= RST_CODE;
			last_af_ff   <= RST_BYTE;
		end else begin
			if (rx_code_valid_i && t1_mode_o)
				last_code_ff <= rx_code_i;
			if (rx_ts0_valid_i && rx_ts0_is_align_i && rx_frame_sync_i && !t1_mode_o)
				last_af_ff <= rx_ts0_i;
		end
	end
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (srst_i);
	chk_read_idle: assert property (
		!(reg_rd_i && mine) |=> reg_rdata_o == RST_BYTE
	) else $error("read data not zero outside a read");
	chk_fw_value: assert property (
		rd_fw |=> reg_rdata_o == FW_REVISION
	) else $error("revision read wrong");
	chk_fw_nowrite: assert property (
		wr_fw |=> $stable(ctrl)
	) else $error("revision write changed state");
	chk_other_port: assert property (
		reg_wr_i && !mine |=> $stable(ctrl)
	) else $error("other port write accepted");
	chk_status_live: assert property (
		rd_link && !t1_mode_o |=> reg_rdata_o[2:0] == $past(hunt)
	) else $error("hunt flags not live");
	chk_search_off: assert property (
		rd_link && !t1_mode_o && !crc4_mode_enable_o && $past(crc4_mode_enable_o) == 1'b0
		|=> reg_rdata_o[7:3] == 5'h00
	) else $error("search count not cleared");
	chk_code_load: assert property (
		rd_code && t1_mode_o && !rx_code_valid_i |=> reg_rdata_o == {2'b00, last_code_ff}
	) else $error("code register wrong");
	chk_align_load: assert property (
		rd_af && !t1_mode_o && !rx_ts0_valid_i |=> reg_rdata_o == last_af_ff
	) else $error("align word wrong");
endmodule : rxohs_regs_chk

bind rxohs_regs rxohs_regs_chk #(.PORT_INDEX(PORT_INDEX), .FW_REVISION(FW_REVISION)) rxohs_regs_chk_i (
	.ref_clk_i, .srst_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .rx_code_valid_i,
	.rx_code_i, .rx_ts0_valid_i, .rx_ts0_is_align_i, .rx_ts0_i, .rx_frame_sync_i,
	.crc4_mf_hunt_active_i, .signaling_mf_hunt_active_i, .frame_align_hunt_active_i,
	.t1_mode_o, .crc4_mode_enable_o, .d4_mode_o, .rx_channel_monitor_select_o
);

// [rxohs_line_model.sv]
`timescale 1ns/1ps
module rxohs_line_model (
	input  logic       ref_clk_i,
	output logic       bit_en_o,
	output logic       bit_o,
	output logic [4:0] slot_o,
	output logic [2:0] pos_o,
	output logic       link_en_o,
	output logic       link_bit_o,
	output logic       link_start_o
);
	initial {bit_en_o, bit_o, slot_o, pos_o, link_en_o, link_bit_o, link_start_o} = 13'h0000;
	// Sends b[7] first; an idle line shows the inverse of the last bit, never a stale copy
	task automatic send(input logic lnk, input logic [4:0] s, input logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			@(posedge ref_clk_i);
			bit_en_o     <= !lnk;
			link_en_o    <= lnk;
			link_start_o <= lnk && i == 0;
			bit_o        <= b[7-i];
			link_bit_o   <= b[7-i];
			slot_o       <= s;
			pos_o        <= 3'(i);
		end
		@(posedge ref_clk_i);
		{bit_en_o, link_en_o, link_start_o} <= 3'h0;
		bit_o      <= ~b[0];
		link_bit_o <= ~b[0];
	endtask : send
endmodule : rxohs_line_model

// [test_rx_overhead_status_regs.sv]
`timescale 1ns/1ps
module test_rx_overhead_status_regs;
	import rxohs_pkg::*;
	localparam logic [7:0] FW = 8'h5A; // Arbitrary revision value
	logic ref_clk_i = 1'b0, srst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
	logic [11:0] reg_addr_i = 12'h000;
	logic [7:0] reg_wdata_i = 8'h00, rx_ts0_i = 8'h00;
	logic rx_fs_bit_en_i = 1'b0, rx_fs_bit_i = 1'b0, rx_fs_start_i = 1'b0, rx_mf_boundary_i = 1'b0;
	logic rx_code_valid_i = 1'b0, rx_slc_valid_i = 1'b0, rx_ts0_valid_i = 1'b0;
	logic rx_ts0_is_align_i = 1'b0, rx_frame_sync_i = 1'b0;
	logic crc4_search_expired_i = 1'b0, crc4_mf_sync_found_i = 1'b0;
	logic [2:0] hunt = 3'h0, rx_slc_m_i = 3'h5;
	logic [5:0] rx_code_i = 6'h00, fsw = 6'h0B;
	logic [10:0] rx_slc_c_i = 11'h5A5;
	logic [1:0] rx_slc_a_i = 2'h2;
	logic [3:0] rx_slc_s_i = 4'h6, rx_slc_sfix_i = 4'hA;
	wire logic [7:0] reg_rdata_o;
	wire logic [4:0] rx_slot_i, rx_channel_monitor_select_o;
	wire logic [2:0] rx_bit_pos_i;
	wire logic rx_bit_en_i, rx_bit_i, rx_link_bit_en_i, rx_link_bit_i, rx_link_start_i;
	wire logic t1_mode_o, crc4_mode_enable_o, d4_mode_o;
	int bad_count = 0, num_checks = 0;

	always #2.5 ref_clk_i = ~ref_clk_i;

	rxohs_line_model rxohs_line_model_i (.ref_clk_i, .bit_en_o(rx_bit_en_i), .bit_o(rx_bit_i),
		.slot_o(rx_slot_i), .pos_o(rx_bit_pos_i), .link_en_o(rx_link_bit_en_i),
		.link_bit_o(rx_link_bit_i), .link_start_o(rx_link_start_i));

	rxohs_regs #(.FW_REVISION(FW)) rxohs_regs_i (.ref_clk_i, .srst_i, .reg_addr_i, .reg_wdata_i,
		.reg_wr_i, .reg_rd_i, .reg_rdata_o, .rx_bit_en_i, .rx_bit_i, .rx_slot_i, .rx_bit_pos_i,
		.rx_link_bit_en_i, .rx_link_bit_i, .rx_link_start_i, .rx_fs_bit_en_i, .rx_fs_bit_i,
		.rx_fs_start_i, .rx_mf_boundary_i, .rx_code_valid_i, .rx_code_i, .rx_slc_valid_i,
		.rx_slc_c_i, .rx_slc_m_i, .rx_slc_a_i, .rx_slc_s_i, .rx_slc_sfix_i, .rx_ts0_valid_i,
		.rx_ts0_is_align_i, .rx_ts0_i, .rx_frame_sync_i, .crc4_mf_hunt_active_i(hunt[2]),
		.signaling_mf_hunt_active_i(hunt[1]), .frame_align_hunt_active_i(hunt[0]),
		.crc4_search_expired_i, .crc4_mf_sync_found_i, .t1_mode_o, .crc4_mode_enable_o,
		.d4_mode_o, .rx_channel_monitor_select_o);

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic tk(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask : tk
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		tk(1);
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		reg_wr_i    <= 1'b1;
		tk(1);
		reg_wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		tk(1);
		reg_addr_i <= a;
		reg_rd_i   <= 1'b1;
		tk(1);
		reg_rd_i <= 1'b0;
		// Data launched at the read edge, taken at the next edge before it drops
		tk(1);
		chk(reg_rdata_o, e);
	endtask : rd
	task automatic expire(input int n);
		repeat (n) begin
			tk(1);
			crc4_search_expired_i <= 1'b1;
			tk(1);
			crc4_search_expired_i <= 1'b0;
		end
	endtask : expire
	task automatic ts0(input logic al, input logic [7:0] b);
		tk(1);
		rx_ts0_valid_i    <= 1'b1;
		rx_ts0_is_align_i <= al;
		rx_ts0_i          <= b;
		tk(1);
		rx_ts0_valid_i <= 1'b0;
	endtask : ts0
	task automatic summarize;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : summarize

	initial begin
		#50000;
		bad_count++;
		summarize();
	end

	initial begin
		tk(5);
		srst_i <= 1'b0;
		for (int o = 0; o < 7; o++) rd(12'h060 + 12'(o), (o == 1) ? FW : RST_BYTE);
		wr(12'h061, 8'hFF);
		rd(12'h061, FW);
		wr(12'h27F, 8'h07);
		tk(1);
		chk({5'h00, d4_mode_o, crc4_mode_enable_o, t1_mode_o}, 8'h00);
		rd(12'h261, RST_BYTE);
		rd(12'h070, RST_BYTE);
		hunt <= 3'h5;
		rd(12'h062, 8'h05);
		hunt <= 3'h2;
		rd(12'h062, 8'h02);
		wr(12'h07F, 8'h02);
		tk(1);
		chk({5'h00, d4_mode_o, crc4_mode_enable_o, t1_mode_o}, 8'h02);
		expire(2);
		rd(12'h062, 8'h02);
		expire(3);
		rd(12'h062, 8'h1A);
		tk(1);
		crc4_mf_sync_found_i <= 1'b1;
		tk(1);
		crc4_mf_sync_found_i <= 1'b0;
		rd(12'h062, 8'h02);
		// 50 expiries of 8 ms is the 400 ms point where the controller gives up
		expire(50);
		rd(12'h062, 8'hC2);
		expire(20);
		rd(12'h062, 8'hFA);
		wr(12'h07F, 8'h00);
		rd(12'h062, 8'h02);
		rx_frame_sync_i <= 1'b1;
		ts0(1'b1, 8'h9B);
		ts0(1'b0, 8'h5F);
		rd(12'h064, 8'h9B);
		rd(12'h065, 8'h5F);
		rx_frame_sync_i <= 1'b0;
		ts0(1'b1, 8'h1B);
		rd(12'h064, 8'h9B);
		wr(12'h07E, 8'h07);
		tk(1);
		chk({3'h0, rx_channel_monitor_select_o}, 8'h07);
		rxohs_line_model_i.send(1'b0, 5'h03, 8'h3C);
		rxohs_line_model_i.send(1'b0, 5'h07, 8'hC3);
		tk(3);
		rd(12'h060, 8'hC3);
		wr(12'h07F, 8'h01);
		for (int i = 0; i < 2; i++) begin
			tk(1);
			rx_code_valid_i <= 1'b1;
			rx_code_i       <= i ? 6'h14 : 6'h2B;
			tk(1);
			rx_code_valid_i <= 1'b0;
			rd(12'h063, i ? 8'h14 : 8'h2B);
		end
		rxohs_line_model_i.send(1'b1, 5'h00, 8'hCA);
		tk(3);
		rd(12'h062, 8'h53);
		tk(1);
		rx_slc_valid_i <= 1'b1;
		tk(1);
		rx_slc_valid_i <= 1'b0;
		rd(12'h064, 8'hA5);
		rd(12'h065, 8'h55);
		rd(12'h066, 8'hB5);
		wr(12'h07F, 8'h05);
		tk(1);
		chk({5'h00, d4_mode_o, crc4_mode_enable_o, t1_mode_o}, 8'h05);
		rxohs_line_model_i.send(1'b1, 5'h00, 8'h0F);
		for (int i = 0; i < 6; i++) begin
			tk(1);
			rx_fs_bit_en_i <= 1'b1;
			rx_fs_bit_i    <= fsw[i];
			rx_fs_start_i  <= i == 0;
		end
		tk(1);
		rx_fs_bit_en_i <= 1'b0;
		rx_fs_start_i  <= 1'b0;
		rx_fs_bit_i    <= ~fsw[5];
		tk(3);
		rd(12'h062, 8'h53);
		tk(1);
		rx_mf_boundary_i <= 1'b1;
		tk(1);
		rx_mf_boundary_i <= 1'b0;
		rd(12'h062, {2'b00, fsw});
		// Mid-run reset must wipe captures and controls alike
		srst_i <= 1'b1;
		tk(2);
		srst_i <= 1'b0;
		rd(12'h060, RST_BYTE);
		rd(12'h064, RST_BYTE);
		chk({5'h00, d4_mode_o, crc4_mode_enable_o, t1_mode_o}, 8'h00);
		summarize();
	end
endmodule : test_rx_overhead_status_regs
